/* File: src/soft_cpu_decoder_defs.vh */
// Overview of operation
// RQ1 - Immediate format: class, immediate, two registers
// RQ2 - Immediate format: A and immediate in, B out
// RQ3 - Sign-extend immediate except logic, unsigned compares
// RQ4 - Register format: three registers, extension, class
// RQ5 - Register format: A, B in, C out
// RQ6 - Constant shifts take amount from extension bits
// RQ7 - Jump format: class and 26-bit target
// RQ8 - Class 0x00 call, 0x01 absolute jump
// RQ9 - Class 0x3A register format, others immediate; code also decodes custom 0x32 in register format
// RQ10 - Unlisted codes are reserved, never decoded
// RQ11 - Load class codes, plain and peripheral
// RQ12 - Store class codes, plain and peripheral
// RQ13 - Branch class codes
// RQ14 - Immediate arithmetic and logic class codes
// RQ15 - Immediate compare class codes
// RQ16 - Data-cache maintenance codes and custom 0x32
// RQ17 - Register arithmetic, multiply, divide extension codes
// RQ18 - Register logical extension codes
// RQ19 - Register compare extension codes
// RQ20 - Shift and rotate extension codes
// RQ21 - Control-flow extension codes
// RQ22 - System extension codes
// RQ23 - Flag reserved codes as illegal instruction
`ifndef SOFT_CPU_DECODER_DEFS_VH
`define SOFT_CPU_DECODER_DEFS_VH
// Field positions
`define F_MCC_MSB 5
`define F_MCC_LSB 0
`define F_IMM_MSB 21
`define F_IMM_LSB 6
`define F_RB_MSB 26
`define F_RB_LSB 22
`define F_RA_MSB 31
`define F_RA_LSB 27
`define F_RC_MSB 21
`define F_RC_LSB 17
`define F_EXT_MSB 16
`define F_EXT_LSB 6
`define F_JT_MSB 31
`define F_JT_LSB 6
`define EXT_SEL_MSB 10
`define EXT_SEL_LSB 5
`define EXT_AMT_MSB 4
`define EXT_AMT_LSB 0
`define LINK_REG 5'h1F
// Operation groups
`define GRP_NONE 4'h0
`define GRP_ARITH 4'h1
`define GRP_CMP 4'h2
`define GRP_LOAD 4'h3
`define GRP_STORE 4'h4
`define GRP_BRANCH 4'h5
`define GRP_JUMP 4'h6
`define GRP_CACHE 4'h7
`define GRP_CUSTOM 4'h8
`define GRP_SHIFT 4'h9
`define GRP_SYSTEM 4'hA
`define GRP_MULDIV 4'hB
`define GRP_LOGIC 4'hC
// Condition codes for branches and compares
`define CND_ALWAYS 3'h0
`define CND_EQ 3'h1
`define CND_NE 3'h2
`define CND_LT 3'h3
`define CND_GE 3'h4
`define CND_LTU 3'h5
`define CND_GEU 3'h6
// Memory access sizes
`define SZ_BYTE 2'h0
`define SZ_HALF 2'h1
`define SZ_WORD 2'h2
// Format codes
`define FMT_I 2'h0
`define FMT_R 2'h1
`define FMT_J 2'h2
// Major class codes
`define MC_CALL 6'h00
`define MC_JMPI 6'h01
`define MC_LDBU 6'h03
`define MC_ADDI 6'h04
`define MC_STB 6'h05
`define MC_JREL 6'h06
`define MC_LDB 6'h07
`define MC_CMPGEI 6'h08
`define MC_LDHU 6'h0B
`define MC_ANDI 6'h0C
`define MC_STH 6'h0D
`define MC_BGE 6'h0E
`define MC_LDH 6'h0F
`define MC_CMPLTI 6'h10
`define MC_INITDA 6'h13
`define MC_ORI 6'h14
`define MC_STW 6'h15
`define MC_BLT 6'h16
`define MC_LDW 6'h17
`define MC_CMPNEI 6'h18
`define MC_FLUSHDA 6'h1B
`define MC_XORI 6'h1C
`define MC_BNE 6'h1E
`define MC_CMPEQI 6'h20
`define MC_LDBUIO 6'h23
`define MC_MULI 6'h24
`define MC_STBIO 6'h25
`define MC_BEQ 6'h26
`define MC_LDBIO 6'h27
`define MC_CMPGEUI 6'h28
`define MC_LDHUIO 6'h2B
`define MC_ANDHI 6'h2C
`define MC_STHIO 6'h2D
`define MC_BGEU 6'h2E
`define MC_LDHIO 6'h2F
`define MC_CMPLTUI 6'h30
`define MC_CUSTOM 6'h32
`define MC_INITD 6'h33
`define MC_ORHI 6'h34
`define MC_STWIO 6'h35
`define MC_BLTU 6'h36
`define MC_LDWIO 6'h37
`define MC_RFMT 6'h3A
`define MC_FLUSHD 6'h3B
`define MC_XORHI 6'h3C
// Extension codes, upper six bits of the extension field
`define XC_ERET 6'h01
`define XC_ROLI 6'h02
`define XC_ROL 6'h03
`define XC_FLUSHP 6'h04
`define XC_RET 6'h05
`define XC_NOR 6'h06
`define XC_MULXUU 6'h07
`define XC_CMPGE 6'h08
`define XC_BRET 6'h09
`define XC_ROR 6'h0B
`define XC_FLUSHI 6'h0C
`define XC_JMP 6'h0D
`define XC_AND 6'h0E
`define XC_CMPLT 6'h10
`define XC_SLLI 6'h12
`define XC_SLL 6'h13
`define XC_OR 6'h16
`define XC_MULXSU 6'h17
`define XC_CMPNE 6'h18
`define XC_SRLI 6'h1A
`define XC_SRL 6'h1B
`define XC_NEXTPC 6'h1C
`define XC_CALLR 6'h1D
`define XC_XOR 6'h1E
`define XC_MULXSS 6'h1F
`define XC_CMPEQ 6'h20
`define XC_DIVU 6'h24
`define XC_DIV 6'h25
`define XC_RDCTL 6'h26
`define XC_MUL 6'h27
`define XC_CMPGEU 6'h28
`define XC_INITI 6'h29
`define XC_TRAP 6'h2D
`define XC_WRCTL 6'h2E
`define XC_CMPLTU 6'h30
`define XC_ADD 6'h31
`define XC_BREAK 6'h34
`define XC_SYNC 6'h36
`define XC_SUB 6'h39
`define XC_SRAI 6'h3A
`define XC_SRA 6'h3B
`endif

/* File: src/ext_code_decoder.v */
`timescale 1ns/100ps
`include "soft_cpu_decoder_defs.vh"
module ext_code_decoder (
   // Upper six bits of the extension field
   input wire [5:0] i_sel,
   // Decoded properties
   output reg o_known,
   output reg [3:0] o_group,
   output reg [2:0] o_cond,
   output reg o_amt_imm,
   output reg o_writes_c
);
   always @* begin
      o_known = 1'b1;
      o_group = `GRP_NONE;
      o_cond = `CND_ALWAYS;
      o_amt_imm = 1'b0;
      o_writes_c = 1'b1;
      case (i_sel)
         `XC_ADD, `XC_SUB: o_group = `GRP_ARITH; // [RQ17]
         `XC_MUL, `XC_MULXSS, `XC_MULXSU, `XC_MULXUU,
         `XC_DIV, `XC_DIVU: o_group = `GRP_MULDIV; // [RQ17]
         `XC_AND, `XC_OR, `XC_XOR,
         `XC_NOR: o_group = `GRP_LOGIC; // [RQ18]
         `XC_CMPGE: begin o_group = `GRP_CMP; o_cond = `CND_GE; end // [RQ19]
         `XC_CMPNE: begin o_group = `GRP_CMP; o_cond = `CND_NE; end
         `XC_CMPGEU: begin o_group = `GRP_CMP; o_cond = `CND_GEU; end
         `XC_CMPLT: begin o_group = `GRP_CMP; o_cond = `CND_LT; end
         `XC_CMPEQ: begin o_group = `GRP_CMP; o_cond = `CND_EQ; end
         `XC_CMPLTU: begin o_group = `GRP_CMP; o_cond = `CND_LTU; end
         `XC_ROL, `XC_ROR, `XC_SLL, `XC_SRL,
         `XC_SRA: o_group = `GRP_SHIFT; // [RQ20]
         `XC_ROLI, `XC_SLLI, `XC_SRLI, `XC_SRAI: begin
            o_group = `GRP_SHIFT;
            o_amt_imm = 1'b1; // [RQ6] [RQ20]
         end
         `XC_ERET, `XC_RET, `XC_BRET, `XC_JMP, `XC_TRAP,
         `XC_BREAK: begin
            o_group = `GRP_JUMP; // [RQ21]
            o_writes_c = 1'b0;
         end
         `XC_CALLR, `XC_NEXTPC: o_group = `GRP_JUMP; // [RQ21]
         `XC_RDCTL: o_group = `GRP_SYSTEM; // [RQ22]
         `XC_WRCTL, `XC_SYNC, `XC_FLUSHP: begin
            o_group = `GRP_SYSTEM; // [RQ22]
            o_writes_c = 1'b0;
         end
         `XC_FLUSHI, `XC_INITI: begin
            o_group = `GRP_CACHE; // [RQ22]
            o_writes_c = 1'b0;
         end
         default: begin
            o_known = 1'b0; // [RQ10]
            o_writes_c = 1'b0;
         end
      endcase
   end
endmodule // ext_code_decoder

/* File: src/soft_cpu_instruction_decoder.v */
`timescale 1ns/100ps
`include "soft_cpu_decoder_defs.vh"
module soft_cpu_instruction_decoder (
   // Clock, reset, enable
   input wire i_sys_clk,
   input wire i_rstn,
   input wire i_ce,
   // Instruction from fetch
   input wire i_instr_valid,
   input wire [31:0] i_instr,
   // Raw fields
   output reg o_valid,
   output reg [1:0] o_format,
   output reg [5:0] o_major_class_code,
   output reg [10:0] o_extension_code,
   output reg [25:0] o_long_jump_target,
   // Operands
   output reg [4:0] o_src1_reg,
   output reg [4:0] o_src2_reg,
   output reg o_src2_is_imm,
   output reg [31:0] o_imm32,
   output reg [4:0] o_dest_reg,
   output reg o_dest_we,
   // Operation class
   output reg [3:0] o_group,
   output reg [2:0] o_cond,
   output reg [1:0] o_mem_size,
   output reg o_mem_signed,
   output reg o_mem_io,
   output reg o_illegal
);
   // Immediate fields and register fields
   wire [5:0] mcc = i_instr[`F_MCC_MSB:`F_MCC_LSB]; // [RQ1] [RQ4]
   wire [15:0] short_immediate = i_instr[`F_IMM_MSB:`F_IMM_LSB]; // [RQ1]
   wire [4:0] reg_a = i_instr[`F_RA_MSB:`F_RA_LSB]; // [RQ1] [RQ4]
   wire [4:0] reg_b = i_instr[`F_RB_MSB:`F_RB_LSB]; // [RQ1] [RQ4]
   wire [4:0] reg_c = i_instr[`F_RC_MSB:`F_RC_LSB]; // [RQ4]
   wire [10:0] extension_code = i_instr[`F_EXT_MSB:`F_EXT_LSB]; // [RQ4]
   wire [25:0] long_jump_target = i_instr[`F_JT_MSB:`F_JT_LSB]; // [RQ7]
   wire [5:0] ext_sel = extension_code[`EXT_SEL_MSB:`EXT_SEL_LSB];
   wire [4:0] shift_amt = extension_code[`EXT_AMT_MSB:`EXT_AMT_LSB];

   // Logical operations and unsigned compares take the immediate unsigned
   function zero_ext;
      input [5:0] code;
      begin
         case (code)
            `MC_ANDI, `MC_ORI, `MC_XORI, `MC_ANDHI, `MC_ORHI, `MC_XORHI,
            `MC_CMPGEUI, `MC_CMPLTUI: zero_ext = 1'b1; // [RQ3]
            default: zero_ext = 1'b0;
         endcase
      end
   endfunction

   function [31:0] extend16;
      input [15:0] value;
      input zext;
      begin
         if (zext) begin
            extend16 = {16'h0000, value};
         end else begin
            extend16 = {{16{value[15]}}, value}; // [RQ3]
         end
      end
   endfunction

   // Extension-code decode for the register format
   wire x_known;
   wire [3:0] x_group;
   wire [2:0] x_cond;
   wire x_amt_imm;
   wire x_writes_c;
   ext_code_decoder u_ext (
      .i_sel(ext_sel),
      .o_known(x_known),
      .o_group(x_group),
      .o_cond(x_cond),
      .o_amt_imm(x_amt_imm),
      .o_writes_c(x_writes_c)
   );

   // Major-class decode for immediate and jump formats
   reg m_known;
   reg [3:0] m_group;
   reg [2:0] m_cond;
   reg [1:0] m_size;
   reg m_signed;
   reg m_io;
   reg m_writes_b;
   always @* begin
      m_known = 1'b1;
      m_group = `GRP_NONE;
      m_cond = `CND_ALWAYS;
      m_size = `SZ_WORD;
      m_signed = 1'b0;
      m_io = 1'b0;
      m_writes_b = 1'b1; // [RQ2]
      case (mcc)
         `MC_CALL, `MC_JMPI: begin
            m_group = `GRP_JUMP; // [RQ8]
            m_writes_b = 1'b0;
         end
         `MC_RFMT: m_writes_b = 1'b0; // [RQ9]
         `MC_LDBU: begin
            m_group = `GRP_LOAD; // [RQ11]
            m_size = `SZ_BYTE;
         end
         `MC_LDB: begin
            m_group = `GRP_LOAD; // [RQ11]
            m_size = `SZ_BYTE;
            m_signed = 1'b1;
         end
         `MC_LDHU: begin
            m_group = `GRP_LOAD; // [RQ11]
            m_size = `SZ_HALF;
         end
         `MC_LDH: begin
            m_group = `GRP_LOAD; // [RQ11]
            m_size = `SZ_HALF;
            m_signed = 1'b1;
         end
         `MC_LDW: m_group = `GRP_LOAD; // [RQ11]
         `MC_LDBUIO: begin
            m_group = `GRP_LOAD; // [RQ11]
            m_size = `SZ_BYTE;
            m_io = 1'b1;
         end
         `MC_LDBIO: begin
            m_group = `GRP_LOAD; // [RQ11]
            m_size = `SZ_BYTE;
            m_signed = 1'b1;
            m_io = 1'b1;
         end
         `MC_LDHUIO: begin
            m_group = `GRP_LOAD; // [RQ11]
            m_size = `SZ_HALF;
            m_io = 1'b1;
         end
         `MC_LDHIO: begin
            m_group = `GRP_LOAD; // [RQ11]
            m_size = `SZ_HALF;
            m_signed = 1'b1;
            m_io = 1'b1;
         end
         `MC_LDWIO: begin
            m_group = `GRP_LOAD; // [RQ11]
            m_io = 1'b1;
         end
         `MC_STB, `MC_STBIO: begin
            m_group = `GRP_STORE; // [RQ12]
            m_size = `SZ_BYTE;
            m_io = (mcc == `MC_STBIO);
            m_writes_b = 1'b0;
         end
         `MC_STH, `MC_STHIO: begin
            m_group = `GRP_STORE; // [RQ12]
            m_size = `SZ_HALF;
            m_io = (mcc == `MC_STHIO);
            m_writes_b = 1'b0;
         end
         `MC_STW, `MC_STWIO: begin
            m_group = `GRP_STORE; // [RQ12]
            m_io = (mcc == `MC_STWIO);
            m_writes_b = 1'b0;
         end
         `MC_JREL, `MC_BLT, `MC_BEQ, `MC_BLTU, `MC_BGE, `MC_BNE,
         `MC_BGEU: begin
            m_group = `GRP_BRANCH; // [RQ13]
            m_writes_b = 1'b0;
            case (mcc)
               `MC_BLT: m_cond = `CND_LT;
               `MC_BEQ: m_cond = `CND_EQ;
               `MC_BLTU: m_cond = `CND_LTU;
               `MC_BGE: m_cond = `CND_GE;
               `MC_BNE: m_cond = `CND_NE;
               `MC_BGEU: m_cond = `CND_GEU;
               default: m_cond = `CND_ALWAYS;
            endcase
         end
         `MC_ADDI: m_group = `GRP_ARITH; // [RQ14]
         `MC_MULI: m_group = `GRP_MULDIV; // [RQ14]
         `MC_ORI, `MC_ORHI, `MC_ANDI, `MC_XORI, `MC_ANDHI,
         `MC_XORHI: m_group = `GRP_LOGIC; // [RQ14]
         `MC_CMPGEI: begin
            m_group = `GRP_CMP; // [RQ15]
            m_cond = `CND_GE;
         end
         `MC_CMPNEI: begin
            m_group = `GRP_CMP; // [RQ15]
            m_cond = `CND_NE;
         end
         `MC_CMPGEUI: begin
            m_group = `GRP_CMP; // [RQ15]
            m_cond = `CND_GEU;
         end
         `MC_CMPLTI: begin
            m_group = `GRP_CMP; // [RQ15]
            m_cond = `CND_LT;
         end
         `MC_CMPEQI: begin
            m_group = `GRP_CMP; // [RQ15]
            m_cond = `CND_EQ;
         end
         `MC_CMPLTUI: begin
            m_group = `GRP_CMP; // [RQ15]
            m_cond = `CND_LTU;
         end
         `MC_INITDA, `MC_FLUSHDA, `MC_INITD, `MC_FLUSHD: begin
            m_group = `GRP_CACHE; // [RQ16]
            m_writes_b = 1'b0;
         end
         `MC_CUSTOM: begin
            // Custom words use the register layout; the unit decides
            m_group = `GRP_CUSTOM; // [RQ16]
            m_writes_b = 1'b0;
         end
         default: begin
            m_known = 1'b0; // [RQ10]
            m_writes_b = 1'b0;
         end
      endcase
   end

   // Operand routing
   reg [1:0] fmt_d;
   reg [4:0] src2_d;
   reg src2_imm_d;
   reg [31:0] imm_d;
   reg [4:0] dest_d;
   reg dest_we_d;
   reg [3:0] group_d;
   reg [2:0] cond_d;
   reg illegal_d;
   always @* begin
      fmt_d = `FMT_I;
      src2_d = reg_b;
      src2_imm_d = 1'b0;
      imm_d = extend16(short_immediate, zero_ext(mcc)); // [RQ3]
      dest_d = reg_b;
      dest_we_d = 1'b0;
      group_d = m_group;
      cond_d = m_cond;
      illegal_d = 1'b0;
      if (mcc == `MC_CALL || mcc == `MC_JMPI) begin
         fmt_d = `FMT_J; // [RQ7] [RQ8]
         // Byte target inside the 256 MByte region
         imm_d = {4'h0, long_jump_target, 2'h0}; // [RQ7]
         dest_d = `LINK_REG;
         dest_we_d = (mcc == `MC_CALL);
      end else if (mcc == `MC_RFMT || mcc == `MC_CUSTOM) begin
         fmt_d = `FMT_R; // [RQ9]
         dest_d = reg_c; // [RQ5]
         if (mcc == `MC_RFMT) begin
            group_d = x_group;
            cond_d = x_cond;
            dest_we_d = x_writes_c; // [RQ5]
            illegal_d = ~x_known; // [RQ23]
            src2_imm_d = x_amt_imm; // [RQ6]
            imm_d = x_amt_imm ? {27'h0000000, shift_amt} : 32'h00000000;
            if (ext_sel == `XC_CALLR) begin
               dest_d = `LINK_REG;
            end
         end else begin
            imm_d = {21'h000000, extension_code};
         end
      end else begin
         // Most immediate-format words: A and immediate in, B out
         src2_imm_d = (m_group != `GRP_STORE) &&
            (m_group != `GRP_BRANCH); // [RQ2]
         dest_we_d = m_writes_b; // [RQ2]
         illegal_d = ~m_known; // [RQ23]
      end
      // Reserved words carry no operation downstream
      if (illegal_d) begin
         group_d = `GRP_NONE; // [RQ10]
         dest_we_d = 1'b0;
      end
   end

   // Output stage; enable low freezes everything
   always @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_valid <= 1'b0;
         o_format <= `FMT_I;
         o_major_class_code <= 6'h00;
         o_extension_code <= 11'h000;
         o_long_jump_target <= 26'h0000000;
         o_src1_reg <= 5'h00;
         o_src2_reg <= 5'h00;
         o_src2_is_imm <= 1'b0;
         o_imm32 <= 32'h00000000;
         o_dest_reg <= 5'h00;
         o_dest_we <= 1'b0;
         o_group <= `GRP_NONE;
         o_cond <= `CND_ALWAYS;
         o_mem_size <= `SZ_WORD;
         o_mem_signed <= 1'b0;
         o_mem_io <= 1'b0;
         o_illegal <= 1'b0;
      end else if (i_ce) begin
         o_valid <= i_instr_valid;
         o_format <= fmt_d;
         o_major_class_code <= mcc;
         o_extension_code <= extension_code;
         o_long_jump_target <= long_jump_target;
         o_src1_reg <= reg_a; // [RQ2] [RQ5]
         o_src2_reg <= src2_d;
         o_src2_is_imm <= src2_imm_d;
         o_imm32 <= imm_d;
         o_dest_reg <= dest_d;
         o_dest_we <= dest_we_d & i_instr_valid;
         o_group <= group_d;
         o_cond <= cond_d;
         o_mem_size <= m_size;
         o_mem_signed <= m_signed;
         o_mem_io <= m_io;
         o_illegal <= illegal_d & i_instr_valid; // [RQ23]
      end
   end
endmodule // soft_cpu_instruction_decoder

/* File: verification/soft_cpu_instruction_decoder_monitor.sv */
`timescale 1ns/100ps
module soft_cpu_instruction_decoder_monitor (
   // Clock and reset
   input wire i_sys_clk,
   input wire i_rstn,
   // Fetch side
   input wire i_ce,
   input wire i_instr_valid,
   input wire [31:0] i_instr,
   // Decoded side
   input wire o_valid,
   input wire [1:0] o_format,
   input wire [5:0] o_major_class_code,
   input wire [10:0] o_extension_code,
   input wire [25:0] o_long_jump_target,
   input wire [4:0] o_src1_reg,
   input wire [4:0] o_src2_reg,
   input wire o_src2_is_imm,
   input wire [31:0] o_imm32,
   input wire [4:0] o_dest_reg,
   input wire o_dest_we,
   input wire o_illegal
);
   localparam [63:0] CLASS_OK = 64'h1CFD_F9F9_59F9_F9FB;
   wire ok = i_ce & i_rstn;
   wire [5:0] mcc = i_instr[5:0];
   wire [5:0] sel = i_instr[16:11];
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   property p_fields;
      $past(ok) |-> o_major_class_code == $past(mcc)
         && o_src1_reg == $past(i_instr[31:27])
         && o_src2_reg == $past(i_instr[26:22]);
   endproperty
   a_fields: assert property (p_fields)
      else $error("class or register field mismatch");
   property p_ext;
      ok |=> o_extension_code == $past(i_instr[16:6]);
   endproperty
   a_ext: assert property (p_ext)
      else $error("extension field mismatch");
   property p_jt;
      ok && mcc[5:1] == 5'h00 |=> o_format == 2'h2
         && o_long_jump_target == $past(i_instr[31:6])
         && o_imm32 == {4'h0, $past(i_instr[31:6]), 2'h0};
   endproperty
   a_jt: assert property (p_jt)
      else $error("jump target mismatch");
   property p_rfmt;
      ok && mcc == 6'h3A && sel == 6'h31 |=> o_format == 2'h1
         && o_dest_reg == $past(i_instr[21:17])
         && o_dest_we == $past(i_instr_valid);
   endproperty
   a_rfmt: assert property (p_rfmt)
      else $error("register format destination mismatch");
   property p_sext;
      $past(ok && mcc == 6'h04) |-> o_src2_is_imm
         && o_imm32 == {{16{$past(i_instr[21])}}, $past(i_instr[21:6])}
         && o_dest_reg == $past(i_instr[26:22]);
   endproperty
   a_sext: assert property (p_sext)
      else $error("signed immediate mismatch");
   property p_zext;
      ok && mcc == 6'h0C |=> o_imm32 == {16'h0, $past(i_instr[21:6])};
   endproperty
   a_zext: assert property (p_zext)
      else $error("unsigned immediate mismatch");
   property p_shamt;
      ok && mcc == 6'h3A && sel == 6'h12 |=> o_src2_is_imm
         && o_imm32 == {27'h0, $past(i_instr[10:6])};
   endproperty
   a_shamt: assert property (p_shamt)
      else $error("constant shift amount mismatch");
   property p_ill;
      ok && i_instr_valid && !CLASS_OK[mcc] |=> o_illegal && !o_dest_we;
   endproperty
   a_ill: assert property (p_ill)
      else $error("reserved class not flagged");
   property p_gate;
      $past(ok && !i_instr_valid) |-> !o_valid && !o_illegal && !o_dest_we;
   endproperty
   a_gate: assert property (p_gate)
      else $error("invalid word had effect");
endmodule // soft_cpu_instruction_decoder_monitor
bind soft_cpu_instruction_decoder soft_cpu_instruction_decoder_monitor
   i_mon (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_ce(i_ce),
   .i_instr_valid(i_instr_valid), .i_instr(i_instr), .o_valid(o_valid),
   .o_format(o_format), .o_major_class_code(o_major_class_code),
   .o_extension_code(o_extension_code),
   .o_long_jump_target(o_long_jump_target), .o_src1_reg(o_src1_reg),
   .o_src2_reg(o_src2_reg), .o_src2_is_imm(o_src2_is_imm),
   .o_imm32(o_imm32), .o_dest_reg(o_dest_reg), .o_dest_we(o_dest_we),
   .o_illegal(o_illegal));

/* File: verification/fetch_stage_model.sv */
`timescale 1ns/100ps
module fetch_stage_model (
   // Word toward the decoder
   output logic o_instr_valid,
   output logic [31:0] o_instr
);
   initial begin
      o_instr_valid = 1'b0;
      o_instr = 32'h0;
   end
   task put(input logic [31:0] w);
      o_instr = w;
      o_instr_valid = 1'b1;
   endtask
   // A released word flips so that no stale value looks valid
   task idle;
      o_instr_valid = 1'b0;
      o_instr = ~o_instr;
   endtask
endmodule // fetch_stage_model

/* File: verification/soft_cpu_instruction_decoder_bench.sv */
`timescale 1ns/100ps
module soft_cpu_instruction_decoder_bench;
   localparam [63:0] CLASS_OK = 64'h1CFD_F9F9_59F9_F9FB;
   localparam [63:0] EXT_OK = 64'h0E53_63F1_FDCD_7BFE;
   // Expected operation group per code, one nibble each, reserved is 0
   localparam [255:0] CLASS_GRP = {
      128'h000C_7100_354C_7802_354C_3002_354B_3002,
      128'h050C_7002_354C_7002_354C_3002_3541_3066};
   localparam [255:0] EXT_GRP = {
      128'h0000_9910_0A06_0012_0A60_0072_BABB_0002,
      128'hBC66_9902_BC00_9902_0C67_9062_BC6A_9960};
   localparam logic [6:0] IMM_TAB [14] = '{7'h04, 7'h24, 7'h08, 7'h10,
      7'h20, 7'h18, 7'h17, 7'h15, 7'h26, 7'h4C, 7'h54, 7'h5C, 7'h68, 7'h70};
   localparam logic [8:0] LD_TAB [5] = '{9'h003, 9'h107, 9'h04B, 9'h14F,
      9'h097};
   localparam logic [7:0] ST_TAB [3] = '{8'h05, 8'h4D, 8'h95};
   localparam logic [8:0] BR_TAB [7] = '{9'h006, 9'h0D6, 9'h066, 9'h176,
      9'h10E, 9'h09E, 9'h1AE};
   localparam logic [8:0] CMP_TAB [6] = '{9'h108, 9'h098, 9'h1A8, 9'h0D0,
      9'h060, 9'h170};
   logic i_sys_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic i_ce = 1'b1;
   wire i_instr_valid;
   wire [31:0] i_instr;
   wire o_valid, o_src2_is_imm, o_dest_we, o_mem_signed, o_mem_io, o_illegal;
   wire [1:0] o_format, o_mem_size;
   wire [5:0] o_major_class_code;
   wire [10:0] o_extension_code;
   wire [25:0] o_long_jump_target;
   wire [4:0] o_src1_reg, o_src2_reg, o_dest_reg;
   wire [31:0] o_imm32;
   wire [3:0] o_group;
   wire [2:0] o_cond;
   int err_total = 0;
   int total_checks = 0;
   fetch_stage_model i_fetch (.o_instr_valid(i_instr_valid),
      .o_instr(i_instr));
   soft_cpu_instruction_decoder i_dut (.i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn), .i_ce(i_ce), .i_instr_valid(i_instr_valid),
      .i_instr(i_instr), .o_valid(o_valid), .o_format(o_format),
      .o_major_class_code(o_major_class_code),
      .o_extension_code(o_extension_code),
      .o_long_jump_target(o_long_jump_target), .o_src1_reg(o_src1_reg),
      .o_src2_reg(o_src2_reg), .o_src2_is_imm(o_src2_is_imm),
      .o_imm32(o_imm32), .o_dest_reg(o_dest_reg), .o_dest_we(o_dest_we),
      .o_group(o_group), .o_cond(o_cond), .o_mem_size(o_mem_size),
      .o_mem_signed(o_mem_signed), .o_mem_io(o_mem_io),
      .o_illegal(o_illegal));
   always #10 i_sys_clk = ~i_sys_clk;
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task complete_run;
      if (err_total == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Words go back to back: one per falling edge, judged one cycle later
   task step(input logic [31:0] w);
      i_fetch.put(w);
      @(negedge i_sys_clk);
   endtask
   task t_classes;
      logic [5:0] c;
      for (int i = 0; i < 64; i++) begin
         c = i[5:0];
         step({5'h03, 5'h09, 5'h0C, 6'h31, 5'h00, c});
         chk(o_illegal, !CLASS_OK[c]);
         chk(o_format, (c == 6'h3A || c == 6'h32) ? 2'h1 :
            (c < 6'h02) ? 2'h2 : 2'h0);
         chk(o_major_class_code, c);
         chk(o_group, CLASS_GRP[{c, 2'h0} +: 4]);
         chk(o_src2_reg, 5'h09);
         if (!CLASS_OK[c])
            chk(o_dest_we, 1'b0);
      end
   endtask
   task t_ext;
      logic [5:0] s;
      logic sh;
      logic [3:0] g;
      for (int i = 0; i < 64; i++) begin
         s = i[5:0];
         g = EXT_GRP[{s, 2'h0} +: 4];
         sh = (s == 6'h02 || s == 6'h12 || s == 6'h1A || s == 6'h3A);
         step({5'h07, 5'h08, 5'h15, s, 5'h0B, 6'h3A});
         chk(o_illegal, !EXT_OK[s]);
         chk(o_extension_code, {s, 5'h0B});
         chk(o_group, g);
         if (EXT_OK[s])
            chk(o_dest_reg, (s == 6'h1D) ? 5'h1F : 5'h15);
         if (EXT_OK[s])
            chk(o_src2_is_imm, sh);
         if (sh)
            chk(o_imm32, 32'h0000_000B);
      end
   endtask
   task t_imm;
      for (int i = 0; i < 14; i++) begin
         step({5'h02, 5'h06, 16'h8001, IMM_TAB[i][5:0]});
         chk(o_imm32, IMM_TAB[i][6] ? 32'h0000_8001 : 32'hFFFF_8001);
      end
      step({5'h02, 5'h06, 16'h7FFF, 6'h04});
      chk(o_dest_reg, 5'h06);
      chk(o_src1_reg, 5'h02);
      chk(o_src2_is_imm, 1'b1);
      chk(o_imm32, 32'h0000_7FFF);
   endtask
   task t_mem;
      logic [8:0] e;
      for (int i = 0; i < 10; i++) begin
         e = LD_TAB[i % 5];
         step({5'h01, 5'h04, 16'h0010, e[5:0] | ((i > 4) ? 6'h20 : 6'h00)});
         chk(o_group, 4'h3);
         chk(o_mem_size, e[7:6]);
         if (e[7:6] != 2'h2)
            chk(o_mem_signed, e[8]);
         chk(o_mem_io, i > 4);
      end
      for (int i = 0; i < 6; i++) begin
         step({5'h01, 5'h04, 16'h0010, ST_TAB[i % 3][5:0] |
            ((i > 2) ? 6'h20 : 6'h00)});
         chk(o_group, 4'h4);
         chk(o_mem_size, ST_TAB[i % 3][7:6]);
         chk(o_mem_io, i > 2);
      end
   endtask
   task t_cond;
      for (int i = 0; i < 7; i++) begin
         step({10'h000, 16'hFFFC, BR_TAB[i][5:0]});
         chk(o_group, 4'h5);
         chk(o_cond, BR_TAB[i][8:6]);
      end
      for (int i = 0; i < 6; i++) begin
         step({10'h000, 16'h0003, CMP_TAB[i][5:0]});
         chk({o_group, 1'b0, o_cond}, {4'h2, 1'b0, CMP_TAB[i][8:6]});
         step({15'h0443, CMP_TAB[i][5:0], 5'h00, 6'h3A});
         chk({o_group, 1'b0, o_cond}, {4'h2, 1'b0, CMP_TAB[i][8:6]});
      end
   endtask
   task t_jump;
      step({26'h2ABCDEF, 6'h00});
      chk(o_format, 2'h2);
      chk(o_long_jump_target, 26'h2ABCDEF);
      chk(o_imm32, {4'h0, 26'h2ABCDEF, 2'h0});
      chk({o_dest_we, o_dest_reg}, {1'b1, 5'h1F});
      step({26'h3FFFFFF, 6'h01});
      chk({o_group, o_dest_we}, {4'h6, 1'b0});
   endtask
   task t_gate;
      step(32'h0000_0006);
      i_fetch.idle;
      @(negedge i_sys_clk);
      chk(o_major_class_code, 6'h39);
      chk({o_valid, o_illegal, o_dest_we}, 3'h0);
      i_ce = 1'b0;
      step({5'h01, 5'h02, 16'h1234, 6'h04});
      chk(o_major_class_code, 6'h39);
      i_ce = 1'b1;
      @(negedge i_sys_clk);
      chk(o_imm32, 32'h0000_1234);
      i_rstn = 1'b0;
      @(negedge i_sys_clk);
      chk({o_valid, o_illegal, o_mem_size}, {2'h0, 2'h2});
      i_rstn = 1'b1;
      step({5'h01, 5'h02, 16'h0000, 6'h3D});
      chk({o_valid, o_illegal}, 2'h3);
   endtask
   // Whole run is under two hundred cycles, so this limit is generous
   initial begin
      #200000;
      err_total++;
      complete_run;
   end
   initial begin
      repeat (6) @(negedge i_sys_clk);
      chk({o_valid, o_illegal, o_mem_size}, {2'h0, 2'h2});
      i_rstn = 1'b1;
      t_classes;
      t_ext;
      t_imm;
      t_mem;
      t_cond;
      t_jump;
      t_gate;
      complete_run;
   end
endmodule // soft_cpu_instruction_decoder_bench
